// ### rtl/ida_core.sv
`include "ida_defines.svh"
`default_nettype none
// Data memory front end with indirect addressing ports.
// Ports and pointers live in sector 0; general RAM is held here and
// every other special location is forwarded to its outside owner.
// Limitation: unused and reserved locations are judged outside.
module ida_core
   import ida_pkg::*;
(
   input  wire logic               ref_clk_i,
   input  wire logic               reset_i,
   input  wire ida_pkg::ida_addr_t addr_i,
   input  wire logic               wr_en_i,
   input  wire logic               rd_en_i,
   input  wire ida_pkg::ida_byte_t wdata_i,
   input  wire ida_pkg::ida_byte_t ext_sfr_rdata_i,
   output ida_pkg::ida_byte_t      rdata_o,
   output logic                    ext_sfr_sel_o,
   output logic                    ext_sfr_wr_o,
   output ida_pkg::ida_addr_t      ext_sfr_addr_o,
   output ida_pkg::ida_byte_t      ext_sfr_wdata_o,
   output ida_pkg::ida_byte_t      sector0_pointer_o,
   output ida_pkg::ida_byte_t      pointer_a_offset_o,
   output ida_pkg::ida_byte_t      pointer_a_sector_o,
   output ida_pkg::ida_byte_t      pointer_b_offset_o,
   output ida_pkg::ida_byte_t      pointer_b_sector_o
);
   import ida_pkg::*;

   // ------------------------------------------------------------
   // Pointer registers
   // ------------------------------------------------------------
   ida_byte_t sector0_pointer;
   ida_byte_t pointer_a_offset;
   ida_byte_t pointer_a_sector;
   ida_byte_t pointer_b_offset;
   ida_byte_t pointer_b_sector;

   ida_addr_t eff_addr;

   // ------------------------------------------------------------
   // Effective address
   // ------------------------------------------------------------
   // Pointers are read combinationally, so a pointer written by one
   // instruction steers the very next indirect access
   ida_resolve u_resolve (
      .addr_i             (addr_i),
      .sector0_pointer_i  (sector0_pointer),
      .pointer_a_offset_i (pointer_a_offset),
      .pointer_a_sector_i (pointer_a_sector),
      .pointer_b_offset_i (pointer_b_offset),
      .pointer_b_sector_i (pointer_b_sector),
      .is_port_o          (),
      .eff_addr_o         (eff_addr)
   );

   // ------------------------------------------------------------
   // Decode of the effective address
   // ------------------------------------------------------------
   wire [7:0] eofs    = eff_addr[7:0];
   wire [2:0] esec    = eff_addr[10:8];
   wire       e_gpr   = (eofs >= `IDA_GPR_BASE);
   wire       e_sec0  = (esec == 3'h0);
   // A pointer aimed at a port address lands on nothing, so a port
   // can never be used to reach itself or another port
   wire       e_port_s0 = e_sec0 && (eofs == `IDA_PORT_SECTOR0);
   wire       e_port_a  = e_sec0 && (eofs == `IDA_PORT_A);
   wire       e_port_b  = e_sec0 && (eofs == `IDA_PORT_B);
   wire       e_port    = e_port_s0 || e_port_a || e_port_b;
   wire       e_p_s0  = e_sec0 && (eofs == `IDA_SECTOR0_PTR);
   wire       e_p_ao  = e_sec0 && (eofs == `IDA_PTR_A_OFS);
   wire       e_p_as  = e_sec0 && (eofs == `IDA_PTR_A_SEC);
   wire       e_p_bo  = e_sec0 && (eofs == `IDA_PTR_B_OFS);
   wire       e_p_bs  = e_sec0 && (eofs == `IDA_PTR_B_SEC);
   wire       e_ptr   = e_p_s0 || e_p_ao || e_p_as || e_p_bo || e_p_bs;
   // Everything that is not RAM, port or pointer goes outside
   wire       e_ext   = !e_gpr && !e_port && !e_ptr;
   // Gating on the effective address drops pointer-borne port writes;
   // a direct port write goes on to its pointer-held address
   wire       wr      = wr_en_i && !e_port;

   // ------------------------------------------------------------
   // General purpose RAM, 8 sectors x 128 bytes, flip-flops
   // ------------------------------------------------------------
   // One bank per sector keeps each write enable a compare of the
   // sector field. No reset, as with a real RAM: unwritten bytes
   // read as unknown.
   wire [6:0]      ram_ofs = eofs[6:0];
   wire            ram_wr  = wr && e_gpr;
   wire ida_byte_t bank_rdata [0:`IDA_SECTORS-1];
   ida_byte_t      ram_rdata;

   generate
      for (genvar s = 0; s < `IDA_SECTORS; s++) begin : g_sector
         ida_byte_t bank [0:`IDA_BANK_DEPTH-1];
         wire       bank_wr = ram_wr && (esec == 3'(s));

         always_ff @(posedge ref_clk_i) begin
            if (bank_wr) begin
               bank[ram_ofs] <= wdata_i;
            end
         end

         assign bank_rdata[s] = bank[ram_ofs];
      end
   endgenerate

   assign ram_rdata = bank_rdata[esec];

   // ------------------------------------------------------------
   // Pointer register updates
   // ------------------------------------------------------------
   // No increment logic here: software steps a pointer by a read,
   // an add in the core and an ordinary write back
   logic wr_p_s0;
   logic wr_p_ao;
   logic wr_p_as;
   logic wr_p_bo;
   logic wr_p_bs;

   assign wr_p_s0 = wr && e_p_s0;
   assign wr_p_ao = wr && e_p_ao;
   assign wr_p_as = wr && e_p_as;
   assign wr_p_bo = wr && e_p_bo;
   assign wr_p_bs = wr && e_p_bs;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sector0_pointer <= `IDA_PTR_RESET;
      end else if (wr_p_s0) begin
         sector0_pointer <= wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pointer_a_offset <= `IDA_PTR_RESET;
      end else if (wr_p_ao) begin
         pointer_a_offset <= wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pointer_a_sector <= `IDA_PTR_RESET;
      end else if (wr_p_as) begin
         pointer_a_sector <= wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pointer_b_offset <= `IDA_PTR_RESET;
      end else if (wr_p_bo) begin
         pointer_b_offset <= wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pointer_b_sector <= `IDA_PTR_RESET;
      end else if (wr_p_bs) begin
         pointer_b_sector <= wdata_i;
      end
   end

   // ------------------------------------------------------------
   // Other special registers live outside; unused and reserved
   // handling is the owner's duty, reads of unused ones give zero
   // ------------------------------------------------------------
   assign ext_sfr_sel_o   = (rd_en_i || wr_en_i) && e_ext;
   assign ext_sfr_wr_o    = wr && e_ext;
   assign ext_sfr_addr_o  = eff_addr;
   assign ext_sfr_wdata_o = wdata_i;

   // ------------------------------------------------------------
   // Read data path
   // ------------------------------------------------------------
   // Idle cycles and reads through a pointer aimed at a port give zero
   wire       rd_zero = !rd_en_i || e_port;

   ida_byte_t next_rdata;
   always_comb begin
      next_rdata = `IDA_ZERO_BYTE;
      if (rd_zero) begin
         next_rdata = `IDA_ZERO_BYTE;
      end else if (e_gpr) begin
         next_rdata = ram_rdata;
      end else if (e_p_s0) begin
         next_rdata = sector0_pointer;
      end else if (e_p_ao) begin
         next_rdata = pointer_a_offset;
      end else if (e_p_as) begin
         next_rdata = pointer_a_sector;
      end else if (e_p_bo) begin
         next_rdata = pointer_b_offset;
      end else if (e_p_bs) begin
         next_rdata = pointer_b_sector;
      end else begin
         next_rdata = ext_sfr_rdata_i;
      end
   end

   // ------------------------------------------------------------
   // Read data register
   // ------------------------------------------------------------
   // Registered so the core sees a settled byte one cycle on
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rdata_o <= `IDA_ZERO_BYTE;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Pointer outputs
   // ------------------------------------------------------------
   assign sector0_pointer_o  = sector0_pointer;
   assign pointer_a_offset_o = pointer_a_offset;
   assign pointer_a_sector_o = pointer_a_sector;
   assign pointer_b_offset_o = pointer_b_offset;
   assign pointer_b_sector_o = pointer_b_sector;
endmodule // ida_core
`default_nettype wire

// ### rtl/ida_defines.svh
// Behaviour
// - Reads through a pointer aimed at any of the three indirect ports return zero.
// - Writes aimed at an indirect port address store nothing there.
// - Indirect port operand redirects the access to its pointer-held address.
// - Sector-0 port with its single pointer reaches only sector 0.
// - Port A forms its address from its offset and sector pointers.
// - Port B forms its address from its own offset and sector pointers.
// - The five pointers are real readable, writable registers.
// - Unused special locations read as zero; the core forwards such reads to the outside owner, which must return the zero.
// - Reserved special locations ignore writes; the core forwards such writes to the outside owner, which must drop them.
// - Direct addressing reaches every sector without pointers.
// - High pointer byte selects sector, low byte selects location.
// - Offsets 00H-7FH are special registers, 80H-FFH general RAM.
// - Extended direct addresses are 11 bits: sector high, offset low.
`ifndef IDA_DEFINES_SVH
`define IDA_DEFINES_SVH

`define IDA_ADDR_W        11
`define IDA_SECTOR_W      3
`define IDA_OFS_W         8
`define IDA_SECTORS       8
`define IDA_BANK_DEPTH    128
`define IDA_PORT_SECTOR0  8'h00
`define IDA_SECTOR0_PTR   8'h01
`define IDA_PORT_A        8'h02
`define IDA_PTR_A_OFS     8'h03
`define IDA_PTR_A_SEC     8'h04
`define IDA_PORT_B        8'h0c
`define IDA_PTR_B_OFS     8'h0d
`define IDA_PTR_B_SEC     8'h0e
`define IDA_GPR_BASE      8'h80
`define IDA_PTR_RESET     8'h00
`define IDA_ZERO_BYTE     8'h00

`endif

// ### rtl/ida_pkg.sv
`default_nettype none
package ida_pkg;
   typedef logic [10:0] ida_addr_t;
   typedef logic [7:0]  ida_byte_t;
   typedef enum logic [1:0] {
      IDA_LOC_NORMAL,
      IDA_LOC_UNUSED,
      IDA_LOC_RESERVED
   } ida_loc_e;
endpackage
`default_nettype wire

// ### rtl/ida_resolve.sv
`include "ida_defines.svh"
`default_nettype none
// Maps an 11-bit direct address to its pointer-held address if it names an indirect port.
module ida_resolve
   import ida_pkg::*;
(
   input  wire ida_pkg::ida_addr_t addr_i,
   input  wire ida_pkg::ida_byte_t sector0_pointer_i,
   input  wire ida_pkg::ida_byte_t pointer_a_offset_i,
   input  wire ida_pkg::ida_byte_t pointer_a_sector_i,
   input  wire ida_pkg::ida_byte_t pointer_b_offset_i,
   input  wire ida_pkg::ida_byte_t pointer_b_sector_i,
   output logic                    is_port_o,
   output ida_pkg::ida_addr_t      eff_addr_o
);
   import ida_pkg::*;

   wire [7:0] ofs      = addr_i[7:0];
   // Ports live only in sector 0
   wire       sec0     = (addr_i[10:8] == 3'h0);
   wire       hit_s0   = sec0 && (ofs == `IDA_PORT_SECTOR0);
   wire       hit_a    = sec0 && (ofs == `IDA_PORT_A);
   wire       hit_b    = sec0 && (ofs == `IDA_PORT_B);

   assign is_port_o = hit_s0 || hit_a || hit_b;

   always_comb begin
      if (hit_s0) begin
         eff_addr_o = {3'h0, sector0_pointer_i};
      end else if (hit_a) begin
         eff_addr_o = {pointer_a_sector_i[2:0], pointer_a_offset_i};
      end else if (hit_b) begin
         eff_addr_o = {pointer_b_sector_i[2:0], pointer_b_offset_i};
      end else begin
         eff_addr_o = addr_i;
      end
   end
endmodule // ida_resolve
`default_nettype wire

// ### verif/ida_core_asserts.sv
`default_nettype none
module ida_core_asserts
   import ida_pkg::*;
(
   input wire logic               ref_clk_i,
   input wire logic               reset_i,
   input wire ida_pkg::ida_addr_t addr_i,
   input wire logic               wr_en_i,
   input wire logic               rd_en_i,
   input wire ida_pkg::ida_byte_t wdata_i,
   input wire ida_pkg::ida_byte_t ext_sfr_rdata_i,
   input wire ida_pkg::ida_byte_t rdata_o,
   input wire logic               ext_sfr_sel_o,
   input wire logic               ext_sfr_wr_o,
   input wire ida_pkg::ida_addr_t ext_sfr_addr_o,
   input wire ida_pkg::ida_byte_t sector0_pointer_o,
   input wire ida_pkg::ida_byte_t pointer_a_offset_o,
   input wire ida_pkg::ida_byte_t pointer_a_sector_o,
   input wire ida_pkg::ida_byte_t pointer_b_offset_o,
   input wire ida_pkg::ida_byte_t pointer_b_sector_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import ida_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_set_ofs_a; wr_en_i && addr_i == 11'h003 ##1 addr_i == 11'h002; endsequence
   property p_ptr_wr; wr_en_i && addr_i == 11'h003 |=> pointer_a_offset_o == $past(wdata_i); endproperty
   a_ptr_wr: assert property (p_ptr_wr) else $error("pointer write lost");
   property p_port0; addr_i == 11'h000 |-> ext_sfr_addr_o == {3'h0, sector0_pointer_o}; endproperty
   a_port0: assert property (p_port0) else $error("sector0 port address");
   property p_port_a; addr_i == 11'h002 |-> ext_sfr_addr_o == {pointer_a_sector_o[2:0], pointer_a_offset_o}; endproperty
   a_port_a: assert property (p_port_a) else $error("port a address");
   property p_port_b; addr_i == 11'h00c |-> ext_sfr_addr_o == {pointer_b_sector_o[2:0], pointer_b_offset_o}; endproperty
   a_port_b: assert property (p_port_b) else $error("port b address");
   property p_direct; addr_i[10:8] != 3'h0 |-> ext_sfr_addr_o == addr_i; endproperty
   a_direct: assert property (p_direct) else $error("direct address");
   property p_gpr; ext_sfr_addr_o[7] |-> !ext_sfr_sel_o; endproperty
   a_gpr: assert property (p_gpr) else $error("ram offset sent outside");
   property p_ext_rd; rd_en_i && ext_sfr_sel_o |=> rdata_o == $past(ext_sfr_rdata_i); endproperty
   a_ext_rd: assert property (p_ext_rd) else $error("outside read data");
   property p_self; rd_en_i && addr_i == 11'h000 && sector0_pointer_o == 8'h00 |=> rdata_o == 8'h00; endproperty
   a_self: assert property (p_self) else $error("port read not zero");
   property p_seen; s_set_ofs_a |-> ext_sfr_addr_o[7:0] == $past(wdata_i); endproperty
   a_seen: assert property (p_seen) else $error("new pointer not used");
   property p_port_wr;
      wr_en_i && ext_sfr_addr_o[10:8] == 3'h0 &&
      (ext_sfr_addr_o[7:0] == 8'h00 || ext_sfr_addr_o[7:0] == 8'h02 || ext_sfr_addr_o[7:0] == 8'h0c)
      |-> !ext_sfr_wr_o && !ext_sfr_sel_o;
   endproperty
   a_port_wr: assert property (p_port_wr) else $error("port write not dropped");
endmodule // ida_core_asserts
bind ida_core ida_core_asserts i_chk (
   .ref_clk_i          (ref_clk_i),
   .reset_i            (reset_i),
   .addr_i             (addr_i),
   .wr_en_i            (wr_en_i),
   .rd_en_i            (rd_en_i),
   .wdata_i            (wdata_i),
   .ext_sfr_rdata_i    (ext_sfr_rdata_i),
   .rdata_o            (rdata_o),
   .ext_sfr_sel_o      (ext_sfr_sel_o),
   .ext_sfr_wr_o       (ext_sfr_wr_o),
   .ext_sfr_addr_o     (ext_sfr_addr_o),
   .sector0_pointer_o  (sector0_pointer_o),
   .pointer_a_offset_o (pointer_a_offset_o),
   .pointer_a_sector_o (pointer_a_sector_o),
   .pointer_b_offset_o (pointer_b_offset_o),
   .pointer_b_sector_o (pointer_b_sector_o)
);
`default_nettype wire

// ### verif/ida_core_tb.sv
`default_nettype none
module ida_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ida_pkg::*;
   logic ref_clk_i = 0, reset_i = 1, wr_en_i = 0, rd_en_i = 0, ext_sfr_sel_o, ext_sfr_wr_o;
   ida_addr_t addr_i = '0, ext_sfr_addr_o;
   ida_byte_t wdata_i = '0, ext_sfr_rdata_i, rdata_o, ext_sfr_wdata_o;
   ida_byte_t sector0_pointer_o, pointer_a_offset_o, pointer_a_sector_o, pointer_b_offset_o, pointer_b_sector_o;
   int n_errors = 0, cmp_count = 0, cycles = 0;
   ida_core i_dut (
      .ref_clk_i          (ref_clk_i),
      .reset_i            (reset_i),
      .addr_i             (addr_i),
      .wr_en_i            (wr_en_i),
      .rd_en_i            (rd_en_i),
      .wdata_i            (wdata_i),
      .ext_sfr_rdata_i    (ext_sfr_rdata_i),
      .rdata_o            (rdata_o),
      .ext_sfr_sel_o      (ext_sfr_sel_o),
      .ext_sfr_wr_o       (ext_sfr_wr_o),
      .ext_sfr_addr_o     (ext_sfr_addr_o),
      .ext_sfr_wdata_o    (ext_sfr_wdata_o),
      .sector0_pointer_o  (sector0_pointer_o),
      .pointer_a_offset_o (pointer_a_offset_o),
      .pointer_a_sector_o (pointer_a_sector_o),
      .pointer_b_offset_o (pointer_b_offset_o),
      .pointer_b_sector_o (pointer_b_sector_o)
   );
   ida_sfr_model i_sfr (
      .ref_clk_i (ref_clk_i),
      .sel_i     (ext_sfr_sel_o),
      .wr_i      (ext_sfr_wr_o),
      .addr_i    (ext_sfr_addr_o),
      .wdata_i   (ext_sfr_wdata_o),
      .rdata_o   (ext_sfr_rdata_i)
   );
   initial forever #20 ref_clk_i = ~ref_clk_i;
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Hang guard, far above the few dozen cycles used
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic chk(input ida_byte_t seen, input ida_byte_t exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
      end
   endtask
   // Holds its request until the next call, so calls run back to back
   task automatic acc(input logic w, input logic r, input ida_addr_t a, input ida_byte_t d);
      wr_en_i = w;
      rd_en_i = r;
      addr_i = a;
      wdata_i = d;
      @(posedge ref_clk_i);
      #1;
   endtask
   task automatic rd(input ida_addr_t a, input ida_byte_t exp);
      acc(0, 1, a, 8'h00);
      chk(rdata_o, exp);
   endtask
   task automatic t_port_a();
      acc(1, 0, 11'h004, 8'h01);
      acc(1, 0, 11'h003, 8'h90);
      acc(1, 0, 11'h002, 8'h55);
      rd(11'h190, 8'h55);
      rd(11'h002, 8'h55);
      rd(11'h003, 8'h90);
      $display("port a test done");
   endtask
   task automatic t_port_b();
      acc(1, 0, 11'h00e, 8'h07);
      acc(1, 0, 11'h00d, 8'hff);
      acc(1, 0, 11'h00c, 8'ha5);
      rd(11'h7ff, 8'ha5);
      rd(11'h00e, 8'h07);
      $display("port b test done");
   endtask
   task automatic t_port0();
      acc(1, 0, 11'h185, 8'h5a);
      acc(1, 0, 11'h001, 8'h85);
      acc(1, 0, 11'h000, 8'h3c);
      rd(11'h085, 8'h3c);
      rd(11'h185, 8'h5a);
      acc(1, 0, 11'h001, 8'h00);
      acc(1, 0, 11'h000, 8'h77);
      rd(11'h000, 8'h00);
      rd(11'h001, 8'h00);
      $display("sector0 port test done");
   endtask
   // Mid-run reset clears every pointer
   task automatic t_reset();
      reset_i = 1;
      acc(0, 0, 11'h000, 8'h00);
      reset_i = 0;
      chk(sector0_pointer_o | pointer_a_offset_o | pointer_a_sector_o | pointer_b_offset_o | pointer_b_sector_o, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_sfr();
      acc(1, 0, 11'h040, 8'hc3);
      acc(1, 0, 11'h041, 8'h11);
      rd(11'h040, 8'hc3);
      rd(11'h041, 8'h96);
      rd(11'h105, 8'h00);
      $display("special register test done");
   endtask
   initial begin
      repeat (3) @(posedge ref_clk_i);
      #1;
      reset_i = 0;
      chk(sector0_pointer_o | pointer_a_offset_o | pointer_a_sector_o | pointer_b_offset_o | pointer_b_sector_o, 8'h00);
      t_port_a();
      t_port_b();
      t_port0();
      t_reset();
      t_sfr();
      finish_test();
   end
endmodule // ida_core_tb
`default_nettype wire

// ### verif/ida_sfr_model.sv
`default_nettype none
module ida_sfr_model
   import ida_pkg::*;
#(parameter ida_pkg::ida_byte_t RSV_VAL = 8'h96)
(
   input  wire logic               ref_clk_i,
   input  wire logic               sel_i,
   input  wire logic               wr_i,
   input  wire ida_pkg::ida_addr_t addr_i,
   input  wire ida_pkg::ida_byte_t wdata_i,
   output ida_pkg::ida_byte_t      rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import ida_pkg::*;
   // Outside special registers: sector 0 holds plain bytes, one
   // reserved byte keeps its value, other sectors read as unused
   localparam ida_addr_t RSV_ADDR = 11'h041;
   ida_byte_t regs [0:127];
   wire       in_s0  = (addr_i[10:7] == 4'h0);
   wire       is_rsv = (addr_i == RSV_ADDR);

   always @(posedge ref_clk_i) begin
      if (sel_i && wr_i && in_s0 && !is_rsv) begin
         regs[addr_i[6:0]] <= wdata_i;
      end
   end

   // Same-cycle read data, as the core expects
   assign rdata_o = !in_s0 ? 8'h00 : (is_rsv ? RSV_VAL : regs[addr_i[6:0]]);
endmodule // ida_sfr_model
`default_nettype wire
